// >>> sim/ssiar_asserts.sv
// checker for the reader's bus handshakes and serial clock
// assumes it is bound to ssiar_top and sees only its ports
`timescale 1ns/100ps
module ssiar_asserts (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic [1:0] s_axi_rresp,
	input wire logic [31:0] s_axi_rdata,
	input wire logic s_axi_awready,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [1:0] s_axi_bresp,
	input wire logic ssi_clk
);
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);
	////////////////////////////////////////
	a_read_answer:
	assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
		else $error("read not answered");
	a_rdata_holds:
	assert property (s_axi_rvalid && !s_axi_rready |=>
		s_axi_rvalid && $stable(s_axi_rdata)) else $error("read dropped");
	a_read_ends: assert property (s_axi_rvalid && s_axi_rready |=>
		!s_axi_rvalid) else $error("read answer repeated");
	a_ar_blocked: assert property (s_axi_rvalid |-> !s_axi_arready)
		else $error("read taken while answering");
	a_write_holds: assert property (s_axi_bvalid && !s_axi_bready |=>
		s_axi_bvalid) else $error("write answer dropped");
	a_aw_blocked: assert property (s_axi_bvalid |-> !s_axi_awready)
		else $error("write taken while answering");
	a_resp_okay: assert property (s_axi_rvalid || s_axi_bvalid |->
		s_axi_rresp == 2'h0 && s_axi_bresp == 2'h0) else $error("bad resp");
	// reset must leave the serial clock idle high and the bus quiet
	a_reset_idle: assert property (disable iff (1'b0) !aresetn |=>
		ssi_clk && !s_axi_rvalid && !s_axi_bvalid) else $error("reset");
	// the bench never sets a half period below two cycles
	a_clk_low_hold:
	assert property ($fell(ssi_clk) |=> !ssi_clk)
		else $error("serial clock low half too short");
endmodule

// >>> sim/ssiar_enc_model.sv
// behavioural absolute encoder on the reader's serial link
// assumes the reader idles its clock high between frames
`timescale 1ns/100ps
module ssiar_enc_model (
	input wire logic ssi_clk,
	output logic ssi_data,
	input wire logic present,
	input wire logic gray,
	input wire logic [5:0] nbits,
	input wire logic [31:0] pos_val
);
	logic [31:0] word; // position frozen for the frame
	logic drv = 1'b1; // line level while attached
	logic busy = 1'b0; // inside a frame
	int k = 0; // bits sent so far
	realtime t_rise = 0.0; // time of the last rising clock edge
	// an absent encoder leaves the line pulled low
	assign ssi_data = present ? drv : 1'b0;
	////////////////////////////////////////
	// a falling edge after a long high time starts a frame and freezes
	// the position, so a frame cut short never skews the next one
	always @(negedge ssi_clk) begin
		if (!busy || ($realtime - t_rise) > 1500.0) begin
			word = gray ? pos_val ^ (pos_val >> 1) : pos_val;
			busy = 1'b1;
			k = 0;
		end
	end
	// each rising edge puts out the next bit; after the last one the
	// line drops low after the bit is sampled, then rises, unblocked
	always @(posedge ssi_clk) begin
		t_rise = $realtime;
		if (busy) begin
			drv = word[nbits - 1 - k];
			k++;
			if (k >= nbits) begin
				busy = 1'b0;
				k = 0;
				drv <= #1100 1'b0;
				drv <= #1800 1'b1;
			end
		end
	end
endmodule

// >>> sim/ssiar_top_test.sv
// register-level bench for the encoder reader
// assumes the encoder model answers on the serial link
`timescale 1ns/100ps
`include "ssiar_defines.svh"
module ssiar_top_test;
	logic aclk = 0, aresetn = 0, present = 1, gray = 1;
	logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
	logic s_axi_arvalid = 0, s_axi_rready = 0;
	logic [4:0] s_axi_awaddr = 5'h00, s_axi_araddr = 5'h00;
	logic [31:0] s_axi_wdata = 32'h0, pos_val = 32'h0;
	logic [3:0] s_axi_wstrb = 4'hF; // full words only
	logic [5:0] nbits = 6'h19;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
	logic s_axi_rvalid, ssi_clk, ssi_data;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	logic [31:0] s_axi_rdata;
	int errors = 0, n_compared = 0;
	ssiar_top DUT (.*);
	ssiar_enc_model u_enc (.*);
	always #25 aclk = ~aclk;
	////////////////////////////////////////
	task chk(input logic [4:0] a, input logic [31:0] seen, exp);
		n_compared++;
		if (seen !== exp) begin
			errors++;
			$display("BAD reg %0h exp %0h seen %0h", a, exp, seen);
		end
	endtask
	// waits end only on the answer; the watchdog covers a hang
	task wr(input logic [4:0] a, input logic [31:0] d);
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		do begin
			@(posedge aclk);
			if (s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wready) s_axi_wvalid <= 1'b0;
		end while (s_axi_bvalid !== 1'b1);
		s_axi_bready <= 1'b0;
	endtask
	task rd(input logic [4:0] a, input logic [31:0] exp);
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do begin
			@(posedge aclk);
			if (s_axi_arready) s_axi_arvalid <= 1'b0;
		end while (s_axi_rvalid !== 1'b1);
		s_axi_rready <= 1'b0;
		chk(a, s_axi_rdata, exp);
	endtask
	task test_done;
		$display("compared %0d errors %0d", n_compared, errors);
		if (errors == 0 && n_compared > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	////////////////////////////////////////
	// the whole run needs some 8000 cycles
	initial begin
		repeat (30000) @(posedge aclk);
		errors++;
		test_done;
	end
	initial begin
		repeat (10) @(posedge aclk);
		aresetn <= 1'b1;
		rd(`SSIAR_OFS_CTRL, 32'h3);
		rd(`SSIAR_OFS_WIDTH, 32'hD0C);
		rd(`SSIAR_OFS_CLKDIV, 32'h14);
		rd(`SSIAR_OFS_PAUSE, 32'h640);
		rd(`SSIAR_OFS_STAT, 32'h0);
		wr(5'h18, 32'hFFFF);
		rd(5'h18, 32'h0);
		// 400 ns link clock, short pause to keep the run brief
		wr(`SSIAR_OFS_CLKDIV, 32'h4);
		wr(`SSIAR_OFS_PAUSE, 32'h28);
		pos_val <= 32'h1ABCDEF;
		repeat (3000) @(posedge aclk);
		rd(`SSIAR_OFS_POS, 32'h1ABCDEF);
		wr(`SSIAR_OFS_CTRL, 32'h2);
		gray <= 1'b0;
		pos_val <= 32'h123456;
		repeat (800) @(posedge aclk);
		rd(`SSIAR_OFS_POS, 32'h123456);
		present <= 1'b0;
		pos_val <= 32'h654321;
		repeat (800) @(posedge aclk);
		rd(`SSIAR_OFS_STAT, 32'h1);
		rd(`SSIAR_OFS_POS, 32'h123456);
		present <= 1'b1;
		repeat (800) @(posedge aclk);
		rd(`SSIAR_OFS_POS, 32'h654321);
		// run bit off: no frames, so the position stays put
		wr(`SSIAR_OFS_CTRL, 32'h0);
		pos_val <= 32'h111111;
		repeat (800) @(posedge aclk);
		rd(`SSIAR_OFS_POS, 32'h654321);
		wr(`SSIAR_OFS_CTRL, 32'h2);
		wr(`SSIAR_OFS_WIDTH, 32'hD14);
		nbits <= 6'h21;
		pos_val <= 32'h7;
		repeat (800) @(posedge aclk);
		rd(`SSIAR_OFS_STAT, 32'h2);
		rd(`SSIAR_OFS_POS, 32'h654321);
		wr(`SSIAR_OFS_WIDTH, 32'hD13);
		nbits <= 6'h20;
		pos_val <= 32'hFEDCBA98;
		repeat (800) @(posedge aclk);
		rd(`SSIAR_OFS_POS, 32'hFEDCBA98);
		rd(`SSIAR_OFS_STAT, 32'h0);
		test_done;
	end
endmodule
bind ssiar_top ssiar_asserts u_chk (.*);

// >>> src/ssiar_defines.svh
// offsets, field positions, reset values and timing counts for the reader
// assumes a 20 MHz system clock and a 32-bit AXI4-Lite register bus
`ifndef SSIAR_DEFINES_SVH
`define SSIAR_DEFINES_SVH

`define SSIAR_CLK_HZ 20000000
`define SSIAR_OFS_CTRL 5'h00
`define SSIAR_OFS_WIDTH 5'h04
`define SSIAR_OFS_CLKDIV 5'h08
`define SSIAR_OFS_PAUSE 5'h0C
`define SSIAR_OFS_POS 5'h10
`define SSIAR_OFS_STAT 5'h14
`define SSIAR_SCLK_KHZ 500
`define SSIAR_HALF_DEF (`SSIAR_CLK_HZ / (`SSIAR_SCLK_KHZ * 1000 * 2))
`define SSIAR_PAUSE_US 80
`define SSIAR_PAUSE_DEF ((`SSIAR_CLK_HZ / 1000000) * `SSIAR_PAUSE_US)
`define SSIAR_REV_DEF 6'h0C
`define SSIAR_ANG_DEF 6'h0D
`define SSIAR_MAX_BITS 7'h20
`define SSIAR_CODE_OK 2'h0
`define SSIAR_CODE_LINK 2'h1
`define SSIAR_CODE_PARAM 2'h2
`define SSIAR_CTRL_GRAY 0
`define SSIAR_CTRL_RUN 1
`define SSIAR_CTRL_DEF 2'h3

`endif

// >>> src/ssiar_pkg.sv
// types shared by the reader
// assumes ssiar_defines.svh supplies the numbers
package ssiar_pkg;
	typedef enum logic [2:0] {
		SSIAR_IDLE = 3'b000,
		SSIAR_LOW = 3'b001,
		SSIAR_HIGH = 3'b010,
		SSIAR_PAUSE = 3'b011,
		SSIAR_DONE = 3'b100
	} ssiar_state_e;
	typedef logic [1:0] ssiar_code_t;
endpackage

// >>> src/ssiar_top.sv
// SSI absolute encoder reader with an AXI4-Lite register slave
// assumes encoder data arrives asynchronously and is synchronised here
//
// What this block does
// - status code 0 ok, 1 link, 2 params
// - broken or absent encoder gives code one
// - width sum above 32 gives code two
// - faults freeze position at last good value
// - good frames resume position updates again
// - position and code read as separate registers
// - gray or binary decode, gray by default
// - serial clock rate configurable, default 500 kHz
// - no new frame during pause after frame
// - frame length from widths, default 12+13
`timescale 1ns/100ps
`include "ssiar_defines.svh"

module ssiar_top (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [4:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [4:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	output logic ssi_clk,
	input wire logic ssi_data
);
	import ssiar_pkg::*;

	////////////////////////////////////////////////////////////////////////
	// configuration and status
	logic [1:0] ctrl_r; // gray select and run enable
	logic [5:0] revolution_count_width_r;
	logic [5:0] angle_bits_width_r;
	logic [15:0] half_r; // system cycles per half serial period
	logic [15:0] pause_r; // system cycles of pause after a frame
	logic [31:0] absolute_position_value_r;
	ssiar_code_t link_fault_code_r;
	logic [6:0] total_bits; // frame length
	logic param_bad;

	assign total_bits = {1'b0, revolution_count_width_r} +
		{1'b0, angle_bits_width_r};
	assign param_bad = (total_bits > `SSIAR_MAX_BITS);

	////////////////////////////////////////////////////////////////////////
	// gray to binary over the valid low bits
	function automatic logic [31:0] gray2bin(input logic [31:0] g,
		input logic [6:0] n);
		logic [31:0] b;
		b = 32'h0;
		if (n > 7'h1F) begin
			b[31] = g[31];
		end
		for (int i = 30; i >= 0; i--) begin
			if (i < n) begin
				b[i] = g[i] ^ b[i + 1];
			end
		end
		return b;
	endfunction

	////////////////////////////////////////////////////////////////////////
	// AXI4-Lite write channel: address and data taken in either order
	logic aw_held_r;
	logic w_held_r;
	logic [4:0] awaddr_r;
	logic [31:0] wdata_r;
	logic do_write;

	assign s_axi_awready = ~aw_held_r & ~s_axi_bvalid;
	assign s_axi_wready = ~w_held_r & ~s_axi_bvalid;
	assign do_write = aw_held_r & w_held_r & ~s_axi_bvalid;
	assign s_axi_bresp = 2'h0;

	// capture address and data, issue response after both
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_held_r <= 1'b0;
			w_held_r <= 1'b0;
			awaddr_r <= 5'h00;
			wdata_r <= 32'h0;
			s_axi_bvalid <= 1'b0;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_held_r <= 1'b1;
				awaddr_r <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_held_r <= 1'b1;
				wdata_r <= s_axi_wdata;
			end
			if (do_write) begin
				aw_held_r <= 1'b0;
				w_held_r <= 1'b0;
				s_axi_bvalid <= 1'b1;
			end else if (s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end

	// register writes; unmapped and read-only words are ignored
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ctrl_r <= `SSIAR_CTRL_DEF;
			revolution_count_width_r <= `SSIAR_REV_DEF;
			angle_bits_width_r <= `SSIAR_ANG_DEF;
			half_r <= 16'(`SSIAR_HALF_DEF);
			pause_r <= 16'(`SSIAR_PAUSE_DEF);
		end else if (do_write) begin
			case ({awaddr_r[4:2], 2'b00})
				`SSIAR_OFS_CTRL: begin
					ctrl_r <= wdata_r[1:0];
				end
				`SSIAR_OFS_WIDTH: begin
					revolution_count_width_r <= wdata_r[5:0];
					angle_bits_width_r <= wdata_r[13:8];
				end
				`SSIAR_OFS_CLKDIV: begin
					// zero would give a one-cycle half, the same as one; it is stored as one
					half_r <= (wdata_r[15:0] == 16'h0) ? 16'h1 :
						wdata_r[15:0];
				end
				`SSIAR_OFS_PAUSE: begin
					pause_r <= wdata_r[15:0];
				end
				default: begin
				end
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////
	// AXI4-Lite read channel, one cycle answer
	assign s_axi_arready = ~s_axi_rvalid;
	assign s_axi_rresp = 2'h0;

	// read mux; unmapped addresses read zero with OKAY
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h0;
		end else if (s_axi_arvalid && s_axi_arready) begin
			s_axi_rvalid <= 1'b1;
			case ({s_axi_araddr[4:2], 2'b00})
				`SSIAR_OFS_CTRL: s_axi_rdata <= {30'h0, ctrl_r};
				`SSIAR_OFS_WIDTH: s_axi_rdata <= {18'h0,
					angle_bits_width_r, 2'h0, revolution_count_width_r};
				`SSIAR_OFS_CLKDIV: s_axi_rdata <= {16'h0, half_r};
				`SSIAR_OFS_PAUSE: s_axi_rdata <= {16'h0, pause_r};
				`SSIAR_OFS_POS: s_axi_rdata <=
					absolute_position_value_r;
				`SSIAR_OFS_STAT: s_axi_rdata <=
					{30'h0, link_fault_code_r};
				default: s_axi_rdata <= 32'h0;
			endcase
		end else if (s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// data pin synchroniser; first stage feeds only the second
	logic data_s1_r;
	logic data_s2_r;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			data_s1_r <= 1'b1;
			data_s2_r <= 1'b1;
		end else begin
			data_s1_r <= ssi_data;
			data_s2_r <= data_s1_r;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// frame sequencer: one cyclic_update_period per frame plus pause
	ssiar_state_e state_r;
	logic [15:0] tick_r; // half-period or pause counter
	logic [6:0] bits_r; // bits left to clock
	logic [31:0] shift_r;
	logic link_ok_r; // line high at frame start and at pause end
	logic frame_end; // one-cycle pulse when a frame is judged

	assign frame_end = (state_r == SSIAR_DONE);

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			state_r <= SSIAR_IDLE;
			tick_r <= 16'h0;
			bits_r <= 7'h0;
			shift_r <= 32'h0;
			ssi_clk <= 1'b1;
			link_ok_r <= 1'b0;
		end else begin
			case (state_r)
				SSIAR_IDLE: begin
					ssi_clk <= 1'b1;
					// a bad width sum never starts a frame
					if (ctrl_r[`SSIAR_CTRL_RUN] && !param_bad) begin
						// idle line must be high, else encoder absent
						link_ok_r <= data_s2_r;
						shift_r <= 32'h0;
						bits_r <= total_bits;
						tick_r <= half_r;
						ssi_clk <= 1'b0;
						state_r <= SSIAR_LOW;
					end
				end
				SSIAR_LOW: begin
					if (tick_r <= 16'h1) begin
						ssi_clk <= 1'b1;
						tick_r <= half_r;
						state_r <= SSIAR_HIGH;
					end else begin
						tick_r <= tick_r - 16'h1;
					end
				end
				SSIAR_HIGH: begin
					if (tick_r <= 16'h1) begin
						// sample just before the next falling edge
						shift_r <= {shift_r[30:0], data_s2_r};
						bits_r <= bits_r - 7'h1;
						tick_r <= half_r;
						if (bits_r <= 7'h1) begin
							// clock stays high; pause follows last edge
							tick_r <= pause_r;
							state_r <= SSIAR_PAUSE;
						end else begin
							ssi_clk <= 1'b0;
							state_r <= SSIAR_LOW;
						end
					end else begin
						tick_r <= tick_r - 16'h1;
					end
				end
				SSIAR_PAUSE: begin
					// waiting out the pause blocks any new frame
					if (tick_r <= 16'h1) begin
						// line must have risen again by the end of the pause
						link_ok_r <= link_ok_r & data_s2_r;
						state_r <= SSIAR_DONE;
					end else begin
						tick_r <= tick_r - 16'h1;
					end
				end
				SSIAR_DONE: begin
					state_r <= SSIAR_IDLE;
				end
				default: begin
					state_r <= SSIAR_IDLE;
				end
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////
	// position and status update at each frame end unless the width sum is bad, which sets code two at once
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			absolute_position_value_r <= 32'h0;
			link_fault_code_r <= `SSIAR_CODE_OK;
		end else if (param_bad) begin
			link_fault_code_r <= `SSIAR_CODE_PARAM;
		end else if (frame_end) begin
			if (link_ok_r) begin
				absolute_position_value_r <= ctrl_r[`SSIAR_CTRL_GRAY] ?
					gray2bin(shift_r, total_bits) : shift_r;
				link_fault_code_r <= `SSIAR_CODE_OK;
			end else begin
				// position left untouched on a fault
				link_fault_code_r <= `SSIAR_CODE_LINK;
			end
		end
	end

endmodule
